// ==== logic/brg_pkg.sv ====
// Constants shared by the bus reset and gap count control block
// How it works
// - Request bit write starts bus reset sequence from idle, restarts it from init, not from reset
// - Same write loads holdoff and gap count
// - Config packet sent or received loads both
// - Two resets without update force gap 63
// - Register-started reset keeps written gap count
// - Register holds packet values, readable for rewrite
package brg_pkg;
  // ==========================================
  // Register 1 field layout
  localparam int REG1_WIDTH = 8;
  localparam int REQ_BIT = 6;
  localparam int HOLDOFF_BIT = 7;
  localparam int GAP_LSB = 0;
  localparam int GAP_WIDTH = 6;
  // ==========================================
  // Reset values and limits
  localparam logic [5:0] GAP_MAX = 6'h3F;
  localparam logic [5:0] GAP_RESET = 6'h3F;
  localparam logic HOLDOFF_RESET = 1'b0;
  localparam logic [1:0] RESETS_TO_REVERT = 2'h2;
  // ==========================================
  // Bus reset duration, then initialization
  localparam int RESET_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = 4;
  localparam int CNT_WIDTH = 4;

  typedef enum logic [1:0] {
    BRG_IDLE = 2'b00,
    BRG_RESET = 2'b01,
    BRG_INIT = 2'b10
  } brg_state_t;
endpackage

// ==== logic/brg_tracker.sv ====
// Consecutive bus reset tracker deciding when the gap count reverts
`timescale 1ns/1ps
module brg_tracker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events
  input wire logic update,
  input wire logic reset_done,
  // Result
  output logic revert
);
  typedef struct packed {
    logic [1:0] count;
    logic revert;
  } brg_trk_t;

  brg_trk_t st;
  brg_trk_t next_st;

  always_comb begin
    next_st = st;
    next_st.revert = 1'b0;
    if (update) begin
      next_st.count = 2'h0;
    end else if (reset_done) begin
      if (st.count + 2'h1 >= brg_pkg::RESETS_TO_REVERT) begin
        next_st.revert = 1'b1;
        next_st.count = brg_pkg::RESETS_TO_REVERT;
      end else begin
        next_st.count = st.count + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign revert = st.revert;
endmodule

// ==== logic/brg_ctrl.sv ====
// Bus reset request, root holdoff and gap count control
`timescale 1ns/1ps
module brg_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register 1 write port from link side
  input wire logic reg1_wr,
  input wire logic [7:0] reg1_wdata,
  // Config packet events, decoded by packet logic on this clock
  input wire logic cfg_rx,
  input wire logic cfg_tx,
  input wire logic cfg_holdoff,
  input wire logic [5:0] cfg_gap,
  // Bus reset from the cable side, a pin
  input wire logic cable_reset,
  // Register 1 read back and status
  output logic [7:0] reg1_rdata,
  output logic root_holdoff,
  output logic [5:0] gap_count,
  output logic bus_reset_active,
  output logic bus_init_active
);
  typedef struct packed {
    brg_pkg::brg_state_t state;
    logic [brg_pkg::CNT_WIDTH-1:0] cnt;
    logic root_holdoff;
    logic [5:0] gap;
    logic cable_s1;
    logic cable_s2;
    logic cable_prev;
    logic done;
    logic reset_out;
    logic init_out;
  } brg_st_t;

  brg_st_t st;
  brg_st_t next_st;
  logic revert;
  logic update;

  function automatic logic [brg_pkg::CNT_WIDTH-1:0] cyc(input int n);
    cyc = brg_pkg::CNT_WIDTH'(n - 1);
  endfunction

  // relied on: holdoff and gap written only alongside the request bit
  wire logic req = reg1_wr && reg1_wdata[brg_pkg::REQ_BIT];
  wire logic cfg = cfg_rx || cfg_tx;
  assign update = req || cfg;

  brg_tracker u_trk (
    .clk(clk),
    .rst_n(rst_n),
    .update(update),
    .reset_done(st.done),
    .revert(revert)
  );

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.cable_s1 = cable_reset;
    next_st.cable_s2 = st.cable_s1;
    next_st.cable_prev = st.cable_s2;
    next_st.done = 1'b0;
    if (revert && !update) begin
      next_st.gap = brg_pkg::GAP_MAX;
    end
    if (req) begin
      next_st.root_holdoff = reg1_wdata[brg_pkg::HOLDOFF_BIT];
      next_st.gap = reg1_wdata[brg_pkg::GAP_LSB +: brg_pkg::GAP_WIDTH];
    end else if (cfg) begin
      next_st.root_holdoff = cfg_holdoff;
      next_st.gap = cfg_gap;
    end
    case (st.state)
      brg_pkg::BRG_IDLE: begin
        if (req || (st.cable_s2 && !st.cable_prev)) begin
          next_st.state = brg_pkg::BRG_RESET;
          next_st.cnt = cyc(brg_pkg::RESET_CYCLES);
        end
      end
      brg_pkg::BRG_RESET: begin
        if (st.cnt == '0) begin
          next_st.state = brg_pkg::BRG_INIT;
          next_st.cnt = cyc(brg_pkg::INIT_CYCLES);
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      brg_pkg::BRG_INIT: begin
        if (req) begin
          next_st.state = brg_pkg::BRG_RESET;
          next_st.cnt = cyc(brg_pkg::RESET_CYCLES);
        end else if (st.cnt == '0) begin
          next_st.state = brg_pkg::BRG_IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: begin
        next_st.state = brg_pkg::BRG_IDLE;
      end
    endcase
    next_st.reset_out = (next_st.state == brg_pkg::BRG_RESET);
    next_st.init_out = (next_st.state == brg_pkg::BRG_INIT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.state <= brg_pkg::BRG_IDLE;
      st.cnt <= '0;
      st.root_holdoff <= brg_pkg::HOLDOFF_RESET;
      st.gap <= brg_pkg::GAP_RESET;
      st.cable_s1 <= 1'b0;
      st.cable_s2 <= 1'b0;
      st.cable_prev <= 1'b0;
      st.done <= 1'b0;
      st.reset_out <= 1'b0;
      st.init_out <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs, all from flip-flops
  assign reg1_rdata = {st.root_holdoff, 1'b0, st.gap};
  assign root_holdoff = st.root_holdoff;
  assign gap_count = st.gap;
  assign bus_reset_active = st.reset_out;
  assign bus_init_active = st.init_out;
endmodule

// ==== dv/brg_ctrl_sva.sv ====
// Checker for bus reset and gap count control
`timescale 1ns/1ps
module brg_ctrl_sva (
  input wire logic clk, rst_n, reg1_wr, cfg_rx, cfg_tx, cfg_holdoff,
  input wire logic [7:0] reg1_wdata, reg1_rdata,
  input wire logic [5:0] cfg_gap, gap_count,
  input wire logic root_holdoff, bus_reset_active, bus_init_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire req = reg1_wr && reg1_wdata[6];
  wire upd = req || cfg_rx || cfg_tx;
  req_start_a: assert property (req |=> bus_reset_active) else $error("no reset");
  wr_load_a: assert property (req |=> reg1_rdata == ($past(reg1_wdata) & 8'hBF))
    else $error("bad write load");
  cfg_load_a: assert property (upd && !req |=> gap_count == $past(cfg_gap)
    && root_holdoff == $past(cfg_holdoff)) else $error("bad cfg load");
  ign_write_a: assert property (reg1_wr && !upd |=> $stable(root_holdoff))
    else $error("write taken");
  read_back_a: assert property (reg1_rdata == {root_holdoff, 1'b0, gap_count})
    else $error("bad readback");
  init_follow_a: assert property ($fell(bus_reset_active) |-> bus_init_active)
    else $error("no init");
  reset_len_a: assert property ($rose(bus_reset_active) |-> bus_reset_active[*8])
    else $error("short reset");
  init_len_a: assert property ($rose(bus_init_active) |-> bus_init_active[*4] ##1
    !bus_init_active) else $error("bad init");
  gap_src_a: assert property ($changed(gap_count) |-> gap_count == 6'h3F || $past(upd))
    else $error("gap moved");
endmodule
bind brg_ctrl brg_ctrl_sva chk (.*);

// ==== dv/brg_link_model.sv ====
// Link side model writing register 1 and sending config packets
`timescale 1ns/1ps
module brg_link_model (
  input wire logic clk,
  input wire logic [7:0] reg1_rdata,
  output logic reg1_wr, cfg_rx, cfg_tx, cfg_holdoff,
  output logic [7:0] reg1_wdata,
  output logic [5:0] cfg_gap
);
  initial {reg1_wr, cfg_rx, cfg_tx, cfg_holdoff, reg1_wdata, cfg_gap} = '0;
  task wr(input logic [7:0] d);
    @(negedge clk) {reg1_wr, reg1_wdata} <= {1'b1, d};
    @(negedge clk) reg1_wr <= 1'b0;
    reg1_wdata <= ~d;
  endtask
  task cfg(input logic tx, input logic [6:0] p);
    @(negedge clk) {cfg_tx, cfg_rx, cfg_holdoff, cfg_gap} <= {tx, !tx, p};
    @(negedge clk) {cfg_tx, cfg_rx, cfg_holdoff, cfg_gap} <= {2'b00, ~p};
  endtask
  // Reset after a sent packet repeats the values read back
  task confirm();
    wr({reg1_rdata[7], 1'b1, reg1_rdata[5:0]});
  endtask
  task other();
    wr({reg1_rdata[7], 7'h7F});
  endtask
endmodule

// ==== dv/bus_reset_gap_count_control_bench.sv ====
// Self-checking bench for bus reset and gap count control
`timescale 1ns/1ps
module bus_reset_gap_count_control_bench;
  logic clk, rst_n, cable_reset, reg1_wr, cfg_rx, cfg_tx, cfg_holdoff;
  logic [7:0] reg1_wdata, reg1_rdata, d;
  logic [5:0] cfg_gap, gap_count;
  logic [6:0] p;
  logic root_holdoff, bus_reset_active, bus_init_active;
  logic [31:0] seed = 32'h9ECE;
  int fails, comparisons, mh, mg, cnt;
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  brg_ctrl dut (.*);
  brg_link_model link (.*);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cmp();
    check(reg1_rdata, {mh[0], 1'b0, mg[5:0]});
    check({7'h00, root_holdoff}, {7'h00, mh[0]});
    check({2'b00, gap_count}, {2'b00, mg[5:0]});
  endtask
  // Lets a bus reset and its initialization run out, counting both phases
  task done();
    int nr, ni;
    nr = 0;
    ni = 0;
    for (int i = 0; i < 40; i++) begin
      if (bus_reset_active === 1'b1) nr++;
      if (bus_init_active === 1'b1) ni++;
      if (ni > 0 && bus_init_active === 1'b0) break;
      @(negedge clk);
    end
    cable_reset = 0;
    check(8'(nr), 8'(brg_pkg::RESET_CYCLES));
    check(8'(ni), 8'(brg_pkg::INIT_CYCLES));
    repeat (3) @(negedge clk);
    cnt++;
    if (cnt >= 2) mg = 63;
  endtask
  task summarize();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    summarize();
  end
  initial begin
    {rst_n, cable_reset} = 0;
    mh = 0;
    mg = 63;
    repeat (3) @(negedge clk);
    rst_n = 1;
    cmp();
    for (int k = 0; k < 4; k++) begin
      d = 8'(rnd());
      link.wr(d | 8'h40);
      mh = d[7];
      mg = d[5:0];
      cnt = 0;
      check({6'h00, bus_reset_active, bus_init_active}, 8'h02);
      cmp();
      done();
      cmp();
      link.wr((d & 8'hBF) ^ 8'h81);
      cmp();
      p = d[6:0] ^ 7'h2A;
      link.cfg(k[0], p);
      mh = p[6];
      mg = p[5:0];
      cnt = 0;
      cmp();
      if (k[0]) link.confirm();
      else link.other();
      if (!k[0]) mg = 63;
      done();
      cmp();
      cable_reset = 1;
      done();
      cmp();
    end
    // Reset in mid-run, while a requested bus reset is under way
    link.wr(8'hC5);
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    mh = 0;
    mg = 63;
    cnt = 0;
    cmp();
    check({6'h00, bus_reset_active, bus_init_active}, 8'h00);
    summarize();
  end
endmodule
